// ==== rtl/can_tx_ctrl_pkg.sv ====
// Purpose: shared constants for the transmit select, abort acknowledge and filter control block
// Assumes: AXI4-Lite register bus, 32-bit data, byte addresses below
// Notes: 8-bit registers sit in the low byte lane, upper bits read zero
package can_tx_ctrl_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_ABORT_ACK = 8'h00;
    localparam logic [7:0] OFS_TX_SELECT = 8'h04;
    localparam logic [7:0] OFS_FILTER_CTRL = 8'h08;
    localparam logic [7:0] OFS_MODE = 8'h0c;
    localparam logic [7:0] OFS_TX_EMPTY = 8'h10;
    localparam logic [7:0] OFS_ABORT_REQ = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
    localparam logic [7:0] OFS_WINDOW = 8'h40;

    // ----------------------------------------------------------------
    // sizes, field positions, codes
    // ----------------------------------------------------------------
    localparam int TX_BUF_COUNT = 3;
    localparam int WINDOW_WORD_COUNT = 4;
    localparam int FILTER_ORG_LSB = 4;
    localparam int FILTER_HIT_LSB = 0;
    localparam int MODE_REQ_BIT = 0;
    localparam int MODE_ACK_BIT = 1;
    localparam logic [1:0] FILTER_TWO_32 = 2'h0;
    localparam logic [1:0] FILTER_FOUR_16 = 2'h1;
    localparam logic [1:0] FILTER_EIGHT_8 = 2'h2;
    localparam logic [1:0] FILTER_CLOSED = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic RESET_INIT_REQ = 1'b0;
    localparam logic [1:0] RESET_FILTER_ORG = FILTER_TWO_32;
    localparam logic [2:0] RESET_FILTER_HIT = 3'h0;

endpackage

// ==== rtl/irq_flag_if.sv ====
// Purpose: carrier between the register logic and the sticky interrupt flag bank
// Assumes: single clock, signals change only after the rising edge
// Notes: none
`timescale 1ns/1ns
interface irq_flag_if #(
    parameter int N = 4
);
    logic [N-1:0] set_events;
    logic status_clear_wr;
    logic mask_wr;
    logic [N-1:0] wdata;
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic irq;
    modport bank (
        input set_events, status_clear_wr, mask_wr, wdata,
        output status, mask, irq
    );
    modport user (
        output set_events, status_clear_wr, mask_wr, wdata,
        input status, mask, irq
    );
endinterface

// ==== rtl/lowest_bit_pick.sv ====
// Purpose: finds the lowest set bit of a vector
// Assumes: purely combinational
// Notes: index is zero when no bit is set
`timescale 1ns/1ns
module lowest_bit_pick #(
    parameter int W = 3
) (
    input wire logic [W-1:0] vec, // candidate bits
    output logic [W-1:0] onehot, // lowest set bit only
    output logic [$clog2(W)-1:0] index, // its position
    output logic any // some bit set
);
    always_comb begin
        onehot = '0;
        index = '0;
        any = 1'b0;
        for (int i = W - 1; i >= 0; i--) begin
            if (vec[i]) begin
                onehot = '0;
                onehot[i] = 1'b1;
                index = i[$clog2(W)-1:0];
                any = 1'b1;
            end
        end
    end
endmodule

// ==== rtl/irq_flag_bank.sv ====
// Purpose: sticky interrupt flags, write-one-to-clear, with mask and one level output
// Assumes: events are one-cycle pulses
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ns
module irq_flag_bank #(
    parameter int N = 4
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // synchronous reset, active low
    irq_flag_if.bank port // flag traffic
);
    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] mask;
        logic irq;
    } bank_state_type;

    bank_state_type s;
    bank_state_type n;

    always_comb begin
        n = s;
        if (port.status_clear_wr) begin
            n.status = s.status & ~port.wdata;
        end
        n.status = n.status | port.set_events;
        if (port.mask_wr) begin
            n.mask = port.wdata;
        end
        n.irq = |(n.status & n.mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign port.status = s.status;
    assign port.mask = s.mask;
    assign port.irq = s.irq;
endmodule

// ==== rtl/can_tx_select_abort_ack_filter_ctrl.sv ====
// Purpose: register side of a CAN controller: transmit buffer select and window,
//          abort request and acknowledge, acceptance filter control, interrupts
// Assumes: engine inputs are synchronous to aclk; event inputs are one-cycle pulses
// Notes: AXI4-Lite slave, one write and one read under way at a time
//
// How it works
// - abort acknowledge flags forced to reset value while init mode is active.
// - abort acknowledge flags always readable; writes to them do nothing.
// - an acknowledge flag sets only when its buffer's abort was granted.
// - clearing a buffer's empty flag clears its acknowledge flag in that write.
// - buffer select register forced to reset value while init mode is active.
// - buffer select writes accepted only outside init mode, else ignored.
// - buffer select reads return only the lowest set bit.
// - lowest set select bit picks which buffer sits in the access window.
// - window access blocked while the selected buffer is scheduled.
// - no window access at all when no buffer is selected.
// - filter control readable always; organisation writable in init only; hit read-only.
// - organisation 00 two 32-bit, 01 four 16-bit, 10 eight 8-bit, 11 closed.
// - closed filter accepts nothing, so the foreground buffer never reloads.
// - hit field holds the binary index of the matching filter.
// - hit field updates whenever a message shifts into the foreground buffer outside init mode while the filter is not closed.
// - empty flag sets after a successful send or a granted abort.
// - abort granted only if not started, or if the attempt failed.
`timescale 1ns/1ns
module can_tx_select_abort_ack_filter_ctrl
    import can_tx_ctrl_pkg::*;
#(
    parameter int NUM_BUF = TX_BUF_COUNT,
    parameter int WIN_WORDS = WINDOW_WORD_COUNT
) (
    input wire logic aclk, // clock, 10 MHz
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [ADDR_W-1:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [ADDR_W-1:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic [NUM_BUF-1:0] tx_busy, // buffer transmission under way
    input wire logic [NUM_BUF-1:0] tx_sent, // pulse: buffer sent successfully
    input wire logic [NUM_BUF-1:0] tx_failed, // pulse: lost arbitration or error
    input wire logic rx_shift, // pulse: message moved to foreground buffer
    input wire logic [2:0] rx_hit_index, // matching filter of that message
    input wire logic [$clog2(NUM_BUF)-1:0] tx_rd_buf, // engine read: buffer
    input wire logic [$clog2(WIN_WORDS)-1:0] tx_rd_word, // engine read: word
    output logic [31:0] tx_rd_data, // engine read data, one cycle later
    output logic [NUM_BUF-1:0] tx_pending, // buffers scheduled for transmission
    output logic [1:0] filter_mode, // filter organisation
    output logic rx_accept_en, // filter not closed and init mode not active
    output logic init_active, // init request and acknowledge both set
    output logic irq // level interrupt
);
    localparam int BI_W = $clog2(NUM_BUF);
    localparam int WI_W = $clog2(WIN_WORDS);
    localparam int NIRQ = NUM_BUF + 1;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic init_req;
        logic init_ack;
        logic init_active;
        logic [NUM_BUF-1:0] tx_empty_flags;
        logic [NUM_BUF-1:0] tx_pending;
        logic [NUM_BUF-1:0] abort_req;
        logic [NUM_BUF-1:0] abort_ack;
        logic [NUM_BUF-1:0] tx_sel;
        logic [1:0] filter_org;
        logic [2:0] filter_hit;
        logic rx_accept_en;
        logic [NUM_BUF-1:0][WIN_WORDS-1:0][31:0] window;
        logic [31:0] tx_rd_data;
    } top_state_type;

    top_state_type s;
    top_state_type n;

    // ----------------------------------------------------------------
    // derived control terms
    // ----------------------------------------------------------------
    logic [NUM_BUF-1:0] sel_onehot;
    logic [BI_W-1:0] sel_idx;
    logic sel_any;
    logic win_open;
    logic tx_regs_writable;
    logic [NUM_BUF-1:0] sent;
    logic [NUM_BUF-1:0] grant;
    logic rx_event;
    logic wr_go;
    logic [5:0] wr_woff;
    logic [5:0] rd_woff;
    logic wr_win_hit;
    logic rd_win_hit;
    logic [7:0] wd8;
    logic lane0;

    irq_flag_if #(.N(NIRQ)) irq_bus ();

    lowest_bit_pick #(.W(NUM_BUF)) u_pick (
        .vec(s.tx_sel),
        .onehot(sel_onehot),
        .index(sel_idx),
        .any(sel_any)
    );

    irq_flag_bank #(.N(NIRQ)) u_irq (
        .aclk(aclk),
        .aresetn(aresetn),
        .port(irq_bus.bank)
    );

    // window usable only when a buffer is selected and that buffer is empty
    assign win_open = sel_any && s.tx_empty_flags[sel_idx];
    assign tx_regs_writable = !s.init_req && !s.init_ack;

    // engine events are frozen while init mode holds the flags
    assign sent = s.init_active ? '0 : (tx_sent & ~s.tx_empty_flags);
    assign grant = s.init_active ? '0 :
        (s.abort_req & ~s.tx_empty_flags & ~sent & (~tx_busy | tx_failed));
    assign rx_event = rx_shift && !s.init_active && (s.filter_org != FILTER_CLOSED);

    assign wr_go = s.aw_held && s.w_held && !s.bvalid;
    assign wr_woff = s.awaddr[7:2] - OFS_WINDOW[7:2];
    assign rd_woff = araddr[7:2] - OFS_WINDOW[7:2];
    assign wr_win_hit = wr_woff < 6'(WIN_WORDS);
    assign rd_win_hit = rd_woff < 6'(WIN_WORDS);
    assign wd8 = s.wdata[7:0];
    assign lane0 = s.wstrb[0];

    // ----------------------------------------------------------------
    // interrupt flag traffic
    // ----------------------------------------------------------------
    assign irq_bus.set_events = {rx_event, grant | sent};
    assign irq_bus.status_clear_wr = wr_go && lane0 && (s.awaddr == OFS_IRQ_STATUS);
    assign irq_bus.mask_wr = wr_go && lane0 && (s.awaddr == OFS_IRQ_MASK);
    assign irq_bus.wdata = s.wdata[NIRQ-1:0];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [NUM_BUF-1:0] txe_clr;
    logic [NUM_BUF-1:0] req_set;

    always_comb begin
        n = s;
        txe_clr = '0;
        req_set = '0;

        // write address and data are taken independently
        if (awvalid && s.awready) begin
            n.aw_held = 1'b1;
            n.awaddr = awaddr;
        end
        if (wvalid && s.wready) begin
            n.w_held = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end

        if (wr_go) begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            if (wr_win_hit) begin
                if (win_open) begin
                    for (int b = 0; b < 4; b++) begin
                        if (s.wstrb[b]) begin
                            n.window[sel_idx][wr_woff[WI_W-1:0]][b*8 +: 8] =
                                s.wdata[b*8 +: 8];
                        end
                    end
                end else begin
                    n.bresp = RESP_SLVERR;
                end
            end else begin
                case (s.awaddr)
                    OFS_ABORT_ACK: begin
                        // flags are set by hardware only
                        n.bresp = RESP_OKAY;
                    end
                    OFS_TX_SELECT: begin
                        if (lane0 && tx_regs_writable) begin
                            n.tx_sel = wd8[NUM_BUF-1:0];
                        end
                    end
                    OFS_FILTER_CTRL: begin
                        if (lane0 && s.init_active) begin
                            n.filter_org = wd8[FILTER_ORG_LSB +: 2];
                        end
                    end
                    OFS_MODE: begin
                        if (lane0) begin
                            n.init_req = wd8[MODE_REQ_BIT];
                        end
                    end
                    OFS_TX_EMPTY: begin
                        // write one to an empty flag schedules that buffer
                        if (lane0 && tx_regs_writable) begin
                            txe_clr = wd8[NUM_BUF-1:0] & s.tx_empty_flags;
                        end
                    end
                    OFS_ABORT_REQ: begin
                        if (lane0 && tx_regs_writable) begin
                            req_set = wd8[NUM_BUF-1:0] & ~s.tx_empty_flags;
                        end
                    end
                    OFS_IRQ_STATUS: begin
                        n.bresp = RESP_OKAY;
                    end
                    OFS_IRQ_MASK: begin
                        n.bresp = RESP_OKAY;
                    end
                    default: begin
                        n.bresp = RESP_SLVERR;
                    end
                endcase
            end
        end

        // ------------------------------------------------------------
        // transmit flags; hardware sets win over software clears
        // ------------------------------------------------------------
        n.tx_empty_flags = (s.tx_empty_flags & ~txe_clr) | grant | sent;
        n.abort_ack = (s.abort_ack & ~txe_clr) | grant;
        n.abort_req = (s.abort_req | req_set) & ~(grant | sent);

        // ------------------------------------------------------------
        // receive side hit indicator
        // ------------------------------------------------------------
        if (rx_event) begin
            n.filter_hit = rx_hit_index;
        end

        // ------------------------------------------------------------
        // init mode handshake and hold
        // ------------------------------------------------------------
        n.init_ack = s.init_req;
        if (s.init_active) begin
            n.abort_ack = '0;
            n.tx_sel = '0;
            n.abort_req = '0;
            n.tx_empty_flags = '1;
        end

        // ------------------------------------------------------------
        // read channel
        // ------------------------------------------------------------
        if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = '0;
            if (rd_win_hit) begin
                if (win_open) begin
                    n.rdata = s.window[sel_idx][rd_woff[WI_W-1:0]];
                end else begin
                    n.rresp = RESP_SLVERR;
                end
            end else begin
                case (araddr)
                    OFS_ABORT_ACK: begin
                        n.rdata = 32'(s.abort_ack);
                    end
                    OFS_TX_SELECT: begin
                        n.rdata = 32'(sel_onehot);
                    end
                    OFS_FILTER_CTRL: begin
                        n.rdata = (32'(s.filter_org) << FILTER_ORG_LSB) |
                            (32'(s.filter_hit) << FILTER_HIT_LSB);
                    end
                    OFS_MODE: begin
                        n.rdata[MODE_REQ_BIT] = s.init_req;
                        n.rdata[MODE_ACK_BIT] = s.init_ack;
                    end
                    OFS_TX_EMPTY: begin
                        n.rdata = 32'(s.tx_empty_flags);
                    end
                    OFS_ABORT_REQ: begin
                        n.rdata = 32'(s.abort_req);
                    end
                    OFS_IRQ_STATUS: begin
                        n.rdata = 32'(irq_bus.status);
                    end
                    OFS_IRQ_MASK: begin
                        n.rdata = 32'(irq_bus.mask);
                    end
                    default: begin
                        n.rresp = RESP_SLVERR;
                    end
                endcase
            end
        end

        // ------------------------------------------------------------
        // handshake readies and registered outputs
        // ------------------------------------------------------------
        n.awready = !n.aw_held && !n.bvalid;
        n.wready = !n.w_held && !n.bvalid;
        n.arready = !n.rvalid;
        n.init_active = n.init_req && n.init_ack;
        n.tx_pending = ~n.tx_empty_flags;
        n.rx_accept_en = !n.init_active && (n.filter_org != FILTER_CLOSED);
        n.tx_rd_data = s.window[tx_rd_buf][tx_rd_word];
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.tx_empty_flags <= '1;
            s.init_req <= RESET_INIT_REQ;
            s.filter_org <= RESET_FILTER_ORG;
            s.filter_hit <= RESET_FILTER_HIT;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign awready = s.awready;
    assign wready = s.wready;
    assign bresp = s.bresp;
    assign bvalid = s.bvalid;
    assign arready = s.arready;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign rvalid = s.rvalid;
    assign tx_rd_data = s.tx_rd_data;
    assign tx_pending = s.tx_pending;
    assign filter_mode = s.filter_org;
    assign rx_accept_en = s.rx_accept_en;
    assign init_active = s.init_active;
    assign irq = irq_bus.irq;

endmodule

// ==== sim/can_ctrl_sva.sv ====
// Purpose: bus and register checks at the block's ports
// Assumes: one clock, synchronous reset active low
// Notes: none
`timescale 1ns/1ns
module can_ctrl_sva
    import can_tx_ctrl_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic awvalid, // aw valid
    input wire logic awready, // aw ready
    input wire logic wvalid, // w valid
    input wire logic wready, // w ready
    input wire logic bvalid, // b valid
    input wire logic arvalid, // ar valid
    input wire logic arready, // ar ready
    input wire logic [31:0] rdata, // read data
    input wire logic [1:0] rresp, // read response
    input wire logic rvalid, // r valid
    input wire logic [1:0] filter_mode, // organisation
    input wire logic rx_accept_en, // filter open
    input wire logic init_active // init mode
);
    logic [1:0] up_reg = '0;
    always_ff @(posedge aclk) up_reg <= aresetn ? {up_reg[0], 1'b1} : '0;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !up_reg[1]);
    a_err_data_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
        else $error("refused read returned data");
    a_org_init_only: assert property (!$stable(filter_mode) |-> $past(init_active))
        else $error("org changed outside init");
    a_closed_no_accept: assert property ((filter_mode == FILTER_CLOSED) [*2] |-> !rx_accept_en)
        else $error("closed filter accepts");
    a_open_mode_accept: assert property
        ((filter_mode != FILTER_CLOSED && !init_active) [*2] |-> rx_accept_en)
        else $error("open filter refuses");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read response late");
    a_write_busy: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    a_read_busy: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
endmodule
bind can_tx_select_abort_ack_filter_ctrl can_ctrl_sva u_sva (.*);

// ==== sim/can_node_model.sv ====
// Purpose: far side of the block: transmit engine and receive path
// Assumes: bench calls pulse and sets busy and read address
// Notes: hit index is scrambled outside the shift pulse
`timescale 1ns/1ns
module can_node_model (
    input wire logic aclk, // clock
    output logic [2:0] tx_busy, // frame on the bus
    output logic [2:0] tx_sent, // pulse: sent
    output logic [2:0] tx_failed, // pulse: attempt failed
    output logic rx_shift, // pulse: frame to foreground
    output logic [2:0] rx_hit_index, // hit of that frame
    output logic [1:0] tx_rd_buf, // engine read buffer
    output logic [1:0] tx_rd_word // engine read word
);
    initial {tx_busy, tx_sent, tx_failed, rx_shift, rx_hit_index, tx_rd_buf, tx_rd_word} = '0;
    task automatic pulse(input logic [2:0] s, input logic [2:0] f, input logic [2:0] h,
                         input logic r);
        @(posedge aclk);
        {tx_sent, tx_failed, rx_hit_index, rx_shift} <= {s, f, h, r};
        @(posedge aclk);
        {tx_sent, tx_failed, rx_shift} <= '0;
        rx_hit_index <= ~h;
    endtask
endmodule

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the CAN register block
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes: none
`timescale 1ns/1ns
module tb_top
    import can_tx_ctrl_pkg::*;
();
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, tx_rd_data;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, rx_shift, rx_accept_en, init_active, irq;
    logic [1:0] bresp, rresp, filter_mode, tx_rd_buf, tx_rd_word;
    logic [2:0] tx_busy, tx_sent, tx_failed, rx_hit_index, tx_pending;
    int failures = 0, samples_checked = 0;
    initial forever #50 aclk = ~aclk;
    can_tx_select_abort_ack_filter_ctrl u_dut (.*);
    can_node_model u_node (.*);
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk($sformatf("bresp@%h", a), 32'(bresp), 32'(r));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk($sformatf("rdata@%h", a), rdata, e);
        chk($sformatf("rresp@%h", a), 32'(rresp), 32'(r));
    endtask
    task automatic t_select();
        rd(OFS_FILTER_CTRL, 32'h0);
        rd(8'h20, 32'h0, RESP_SLVERR);
        rd(OFS_TX_EMPTY, 32'h7);
        wr(OFS_TX_SELECT, 32'h7);
        rd(OFS_TX_SELECT, 32'h1);
        wr(OFS_TX_SELECT, 32'hf6);
        rd(OFS_TX_SELECT, 32'h2);
        wr(OFS_TX_SELECT, 32'h4);
        wr(OFS_WINDOW, 32'hc0de0002);
        wr(OFS_TX_SELECT, 32'h6);
        wr(OFS_WINDOW + 8'h4, 32'hc0de0011);
        wr(OFS_TX_SELECT, 32'h4);
        rd(OFS_WINDOW, 32'hc0de0002);
        rd(OFS_WINDOW + 8'h4, 32'h0);
        u_node.tx_rd_buf <= 2'h1;
        u_node.tx_rd_word <= 2'h1;
        repeat (2) @(posedge aclk);
        chk("tx_rd_data", tx_rd_data, 32'hc0de0011);
        wr(OFS_TX_SELECT, 32'h0);
        rd(OFS_WINDOW, 32'h0, RESP_SLVERR);
        wr(OFS_WINDOW, 32'h1, RESP_SLVERR);
        $display("done select");
    endtask
    task automatic t_abort();
        wr(OFS_TX_SELECT, 32'h2);
        wr(OFS_TX_EMPTY, 32'h2);
        rd(OFS_TX_EMPTY, 32'h5);
        chk("tx_pending", 32'(tx_pending), 32'h2);
        rd(OFS_WINDOW, 32'h0, RESP_SLVERR);
        wr(OFS_WINDOW, 32'h5, RESP_SLVERR);
        wr(OFS_IRQ_MASK, 32'h2);
        wr(OFS_ABORT_REQ, 32'h2);
        rd(OFS_ABORT_ACK, 32'h2);
        rd(OFS_TX_EMPTY, 32'h7);
        chk("irq", 32'(irq), 32'h1);
        wr(OFS_ABORT_ACK, 32'h0);
        rd(OFS_ABORT_ACK, 32'h2);
        wr(OFS_IRQ_STATUS, 32'h2);
        rd(OFS_IRQ_STATUS, 32'h0);
        chk("irq", 32'(irq), 32'h0);
        wr(OFS_TX_EMPTY, 32'h2);
        rd(OFS_ABORT_ACK, 32'h0);
        u_node.tx_busy <= 3'h2;
        wr(OFS_ABORT_REQ, 32'h2);
        rd(OFS_ABORT_ACK, 32'h0);
        rd(OFS_ABORT_REQ, 32'h2);
        u_node.pulse(3'h0, 3'h2, 3'h0, 1'b0);
        u_node.tx_busy <= 3'h0;
        rd(OFS_ABORT_ACK, 32'h2);
        wr(OFS_TX_EMPTY, 32'h2);
        u_node.pulse(3'h2, 3'h0, 3'h0, 1'b0);
        rd(OFS_TX_EMPTY, 32'h7);
        rd(OFS_ABORT_ACK, 32'h0);
        wr(OFS_IRQ_MASK, 32'h0);
        rd(OFS_IRQ_STATUS, 32'h2);
        chk("irq", 32'(irq), 32'h0);
        wr(OFS_IRQ_STATUS, 32'h2);
        wr(OFS_TX_EMPTY, 32'h2);
        wr(OFS_ABORT_REQ, 32'h2);
        $display("done abort");
    endtask
    task automatic t_init();
        wr(OFS_FILTER_CTRL, 32'h10);
        rd(OFS_FILTER_CTRL, 32'h0);
        wr(OFS_MODE, 32'h1);
        rd(OFS_MODE, 32'h3);
        chk("init_active", 32'(init_active), 32'h1);
        rd(OFS_ABORT_ACK, 32'h0);
        rd(OFS_TX_SELECT, 32'h0);
        wr(OFS_TX_SELECT, 32'h1);
        rd(OFS_TX_SELECT, 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_FILTER_CTRL, 32'(m * 16 + 15));
            rd(OFS_FILTER_CTRL, 32'(m * 16));
            chk("filter_mode", 32'(filter_mode), 32'(m));
        end
        wr(OFS_MODE, 32'h0);
        rd(OFS_MODE, 32'h0);
        wr(OFS_TX_SELECT, 32'h4);
        rd(OFS_TX_SELECT, 32'h4);
        $display("done init");
    endtask
    task automatic t_filter();
        chk("rx_accept_en", 32'(rx_accept_en), 32'h0);
        u_node.pulse(3'h0, 3'h0, 3'h5, 1'b1);
        rd(OFS_FILTER_CTRL, 32'h30);
        wr(OFS_MODE, 32'h1);
        wr(OFS_FILTER_CTRL, 32'h20);
        wr(OFS_MODE, 32'h0);
        rd(OFS_IRQ_STATUS, 32'h2);
        chk("rx_accept_en", 32'(rx_accept_en), 32'h1);
        u_node.pulse(3'h0, 3'h0, 3'h5, 1'b1);
        rd(OFS_FILTER_CTRL, 32'h25);
        u_node.pulse(3'h0, 3'h0, 3'h7, 1'b1);
        rd(OFS_FILTER_CTRL, 32'h27);
        wr(OFS_IRQ_MASK, 32'h8);
        rd(OFS_IRQ_STATUS, 32'ha);
        chk("irq", 32'(irq), 32'h1);
        wr(OFS_IRQ_STATUS, 32'hf);
        rd(OFS_IRQ_STATUS, 32'h0);
        chk("irq", 32'(irq), 32'h0);
        $display("done filter");
    endtask
    task automatic summarize();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_select();
        t_abort();
        t_init();
        t_filter();
        summarize();
    end
    initial begin
        #400000;
        failures++;
        summarize();
    end
endmodule
